// >>> design/status_indicator.sv
// Purpose: nine bit indicators and a text code for a two-axis drive panel
// Assumes: axis inputs come from logic on i_ref_clk; key and clear are pins
// Notes: registers on a plain strobe port, read data one cycle later
//
// The plain strobed port and the address map are this design's own decisions.
module status_indicator #(
    parameter int BLINK_CYCLES = status_ind_pkg::BLINK_CYC
) (
    // clock and reset
    input logic i_ref_clk,
    input logic i_arst_n,
    // register port
    input logic [7:0] i_addr,
    input logic [31:0] i_wdata,
    input logic i_wr,
    input logic i_rd,
    output logic [31:0] o_rdata,
    // axis conditions
    input status_ind_pkg::axis_in_t i_axis_a,
    input status_ind_pkg::axis_in_t i_axis_b,
    input logic i_main_power_ready,
    // panel
    input logic i_status_mode,
    input logic i_set_key,
    input logic i_alarm_clear_input_n,
    // display
    output logic [8:0] o_ind,
    output status_ind_pkg::text_code_t o_text,
    output logic [7:0] o_alarm_num,
    // interrupt
    output logic o_irq
);

    localparam int BLINK_W_L = status_ind_pkg::BLINK_W;
    localparam logic [BLINK_W_L-1:0] BLINK_LAST = BLINK_W_L'(BLINK_CYCLES - 1);

    logic rst_n;
    logic [1:0] pins_q;
    logic key_prev;
    logic clr_prev;
    logic clr_evt;
    status_ind_pkg::ctrl_mode_t mode;
    logic [15:0] spd_win;
    logic [15:0] pos_win;
    logic [15:0] rot_thr;
    logic [3:0] irq_stat;
    logic [3:0] irq_mask;
    logic [3:0] irq_evt;
    logic [BLINK_W_L-1:0] blink_cnt;
    logic blink_en;
    logic blink;
    logic alm_a;
    logic alm_b;
    logic [7:0] num_a;
    logic [7:0] num_b;
    logic pwr_prev;
    logic ot_prev;
    logic pos_mode;
    logic a_within;
    logic a_over;
    logic b_within;
    logic b_over;
    logic signed [15:0] a_meas;
    logic signed [15:0] a_ref;
    logic [15:0] a_win;
    logic [8:0] next_ind;
    status_ind_pkg::text_code_t next_text;
    logic [7:0] next_num;

    // reset release and pin synchronisers
    sync2 #(.W(1)) u_rst_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_d(1'b1),
        .o_q(rst_n)
    );

    sync2 #(.W(2)) u_pin_sync (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(rst_n),
        .i_d({i_set_key, ~i_alarm_clear_input_n}),
        .o_q(pins_q)
    );

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            key_prev <= 1'b0;
            clr_prev <= 1'b0;
        end else begin
            key_prev <= pins_q[1];
            clr_prev <= pins_q[0];
        end
    end

    // a key press only clears while the panel shows status
    assign clr_evt = (pins_q[1] & ~key_prev & i_status_mode)
                   | (pins_q[0] & ~clr_prev);

    // register writes
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode <= status_ind_pkg::MODE_SPEED;
            spd_win <= status_ind_pkg::SPD_WIN_RST;
            pos_win <= status_ind_pkg::POS_WIN_RST;
            rot_thr <= status_ind_pkg::ROT_THR_RST;
            irq_mask <= status_ind_pkg::IRQ_MASK_RST;
        end else if (i_wr) begin
            case (i_addr)
                status_ind_pkg::ADDR_CTRL: begin
                    mode <= status_ind_pkg::ctrl_mode_t'(
                        i_wdata[status_ind_pkg::CTRL_MODE_LSB +: 2]);
                end
                status_ind_pkg::ADDR_SPD_WIN: spd_win <= i_wdata[15:0];
                status_ind_pkg::ADDR_POS_WIN: pos_win <= i_wdata[15:0];
                status_ind_pkg::ADDR_ROT_THR: rot_thr <= i_wdata[15:0];
                status_ind_pkg::ADDR_IRQ_MASK: irq_mask <= i_wdata[3:0];
                default: ;
            endcase
        end
    end

    // register reads, answered in the following cycle
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_rdata <= 32'h0000_0000;
        end else if (i_rd) begin
            case (i_addr)
                status_ind_pkg::ADDR_CTRL: o_rdata <= {30'h0, mode};
                status_ind_pkg::ADDR_SPD_WIN: o_rdata <= {16'h0, spd_win};
                status_ind_pkg::ADDR_POS_WIN: o_rdata <= {16'h0, pos_win};
                status_ind_pkg::ADDR_ROT_THR: o_rdata <= {16'h0, rot_thr};
                status_ind_pkg::ADDR_VIEW: o_rdata <= {12'h0, o_alarm_num, o_text, o_ind};
                status_ind_pkg::ADDR_IRQ_STAT: o_rdata <= {28'h0, irq_stat};
                status_ind_pkg::ADDR_IRQ_MASK: o_rdata <= {28'h0, irq_mask};
                default: o_rdata <= 32'h0000_0000;
            endcase
        end else begin
            o_rdata <= 32'h0000_0000;
        end
    end

    // flash rate divider
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            blink_cnt <= '0;
            blink <= 1'b0;
        end else if (blink_en) begin
            blink_cnt <= '0;
            blink <= ~blink;
        end else begin
            blink_cnt <= blink_cnt + 1'b1;
        end
    end

    assign blink_en = blink_cnt == BLINK_LAST;

    // alarm latches; a raised alarm wins over a clear in the same cycle
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            alm_a <= 1'b0;
            alm_b <= 1'b0;
            num_a <= 8'h00;
            num_b <= 8'h00;
        end else begin
            if (i_axis_a.alarm) begin
                alm_a <= 1'b1;
                num_a <= i_axis_a.alarm_num;
            end else if (clr_evt) begin
                alm_a <= 1'b0;
            end
            if (i_axis_b.alarm) begin
                alm_b <= 1'b1;
                num_b <= i_axis_b.alarm_num;
            end else if (clr_evt) begin
                alm_b <= 1'b0;
            end
        end
    end

    // axis A compares position error in position mode, speed otherwise
    assign pos_mode = mode == status_ind_pkg::MODE_POSITION;
    assign a_meas = pos_mode ? i_axis_a.pos_err : i_axis_a.speed;
    assign a_ref = pos_mode ? 16'sh0000 : i_axis_a.cmd_speed;
    assign a_win = pos_mode ? pos_win : spd_win;

    axis_compare u_cmp_a (
        .i_meas(a_meas),
        .i_ref(a_ref),
        .i_window(a_win),
        .i_torque(i_axis_a.torque),
        .i_rated(i_axis_a.rated_torque),
        .o_within(a_within),
        .o_over_torque(a_over)
    );

    axis_compare u_cmp_b (
        .i_meas(i_axis_b.speed),
        .i_ref(i_axis_b.cmd_speed),
        .i_window(rot_thr),
        .i_torque(i_axis_b.torque),
        .i_rated(i_axis_b.rated_torque),
        .o_within(b_within),
        .o_over_torque(b_over)
    );

    // indicator and text selection
    always_comb begin
        next_ind[0] = i_axis_a.servo_on;
        next_ind[1] = a_within;
        next_ind[2] = a_over;
        next_ind[3] = (i_axis_a.fwd_prohibit & i_axis_a.rev_prohibit) ? blink
                    : i_axis_a.fwd_prohibit;
        next_ind[4] = i_axis_b.servo_on;
        next_ind[5] = b_over;
        next_ind[6] = b_within;
        next_ind[7] = (i_axis_b.fwd_prohibit & i_axis_b.rev_prohibit) ? blink
                    : i_axis_b.fwd_prohibit;
        next_ind[8] = i_main_power_ready;
        next_num = 8'h00;
        if (alm_a) begin
            next_text = status_ind_pkg::TXT_A_ALARM;
            next_num = num_a;
        end else if (alm_b) begin
            next_text = status_ind_pkg::TXT_B_ALARM;
            next_num = num_b;
        end else if (i_axis_a.fwd_prohibit | i_axis_a.rev_prohibit) begin
            next_text = status_ind_pkg::TXT_A_OVERTRAVEL;
        end else if (i_axis_b.fwd_prohibit | i_axis_b.rev_prohibit) begin
            next_text = status_ind_pkg::TXT_B_OVERTRAVEL;
        end else if (i_axis_a.servo_on) begin
            next_text = status_ind_pkg::TXT_A_ON;
        end else if (i_axis_b.servo_on) begin
            next_text = status_ind_pkg::TXT_B_ON;
        end else begin
            next_text = status_ind_pkg::TXT_BOTH_OFF;
        end
    end

    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_ind <= 9'h000;
            o_text <= status_ind_pkg::TXT_BOTH_OFF;
            o_alarm_num <= 8'h00;
        end else begin
            o_ind <= next_ind;
            o_text <= next_text;
            o_alarm_num <= next_num;
        end
    end

    // interrupt events: alarm latched, supply lost, overtravel entered
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_prev <= 1'b0;
            ot_prev <= 1'b0;
        end else begin
            pwr_prev <= i_main_power_ready;
            ot_prev <= next_ind[3] | next_ind[7] | i_axis_a.rev_prohibit
                     | i_axis_b.rev_prohibit;
        end
    end

    always_comb begin
        irq_evt = 4'h0;
        irq_evt[status_ind_pkg::IRQ_ALM_A] = i_axis_a.alarm & ~alm_a;
        irq_evt[status_ind_pkg::IRQ_ALM_B] = i_axis_b.alarm & ~alm_b;
        irq_evt[status_ind_pkg::IRQ_PWR_LOST] = pwr_prev & ~i_main_power_ready;
        irq_evt[status_ind_pkg::IRQ_OVERTRAVEL] = ~ot_prev
            & (i_axis_a.fwd_prohibit | i_axis_a.rev_prohibit
               | i_axis_b.fwd_prohibit | i_axis_b.rev_prohibit);
    end

    // write one to clear; a new event in the same cycle keeps its bit set
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_stat <= 4'h0;
        end else if (i_wr && i_addr == status_ind_pkg::ADDR_IRQ_STAT) begin
            irq_stat <= (irq_stat & ~i_wdata[3:0]) | irq_evt;
        end else begin
            irq_stat <= irq_stat | irq_evt;
        end
    end

    assign o_irq = |(irq_stat & irq_mask);

    // checks
    property p_a_on;
        @(posedge i_ref_clk) disable iff (!rst_n)
        i_axis_a.servo_on |=> o_ind[0];
    endproperty
    a_a_on: assert property (p_a_on) else $error("axis A on lamp dark");

    property p_b_on;
        @(posedge i_ref_clk) disable iff (!rst_n)
        !i_axis_b.servo_on |=> !o_ind[4];
    endproperty
    a_b_on: assert property (p_b_on) else $error("axis B on lamp lit");

    property p_spd_match;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (!pos_mode && i_axis_a.speed == i_axis_a.cmd_speed && spd_win != 16'h0)
        |=> o_ind[1];
    endproperty
    a_spd_match: assert property (p_spd_match) else $error("speed match lamp dark");

    property p_pos_done;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (pos_mode && i_axis_a.pos_err == 16'sh0000 && pos_win != 16'h0 &&
         i_axis_a.speed != i_axis_a.cmd_speed) |=> o_ind[1];
    endproperty
    a_pos_done: assert property (p_pos_done) else $error("position lamp dark");

    property p_limit_fwd;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_axis_a.fwd_prohibit && !i_axis_a.rev_prohibit) |=> o_ind[3];
    endproperty
    a_limit_fwd: assert property (p_limit_fwd) else $error("forward limit lamp");

    property p_limit_flash;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (i_axis_b.fwd_prohibit && i_axis_b.rev_prohibit) |=> o_ind[7] == $past(blink);
    endproperty
    a_limit_flash: assert property (p_limit_flash) else $error("limit flash");

    property p_power;
        @(posedge i_ref_clk) disable iff (!rst_n)
        $fell(i_main_power_ready) |-> ##1 !o_ind[8];
    endproperty
    a_power: assert property (p_power) else $error("supply lamp lit");

    property p_both_off;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (!alm_a && !alm_b && !i_axis_a.servo_on && !i_axis_b.servo_on &&
         !i_axis_a.fwd_prohibit && !i_axis_a.rev_prohibit &&
         !i_axis_b.fwd_prohibit && !i_axis_b.rev_prohibit)
        |=> o_text == status_ind_pkg::TXT_BOTH_OFF;
    endproperty
    a_both_off: assert property (p_both_off) else $error("both off code");

    property p_alarm_first;
        @(posedge i_ref_clk) disable iff (!rst_n)
        i_axis_a.alarm ##1 1'b1 |=> o_text == status_ind_pkg::TXT_A_ALARM;
    endproperty
    a_alarm_first: assert property (p_alarm_first) else $error("alarm code");

    property p_clear;
        @(posedge i_ref_clk) disable iff (!rst_n)
        (clr_evt && !i_axis_a.alarm && !i_axis_b.alarm) |=> !alm_a && !alm_b;
    endproperty
    a_clear: assert property (p_clear) else $error("alarm not cleared");

endmodule

// >>> design/status_ind_pkg.sv
// Purpose: shared constants and types of the two-axis status indicator
// Assumes: 100 MHz clock, 32-bit register words at byte addresses
// Notes: window defaults are in rpm or pulses, as the comparators see them
package status_ind_pkg;

    // clock and flash timing
    localparam int CLK_HZ = 100_000_000;
    localparam int BLINK_MS = 250;
    localparam int BLINK_CYC = BLINK_MS * (CLK_HZ / 1000);
    localparam int BLINK_W = 25;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SPD_WIN = 8'h04;
    localparam logic [7:0] ADDR_POS_WIN = 8'h08;
    localparam logic [7:0] ADDR_ROT_THR = 8'h0c;
    localparam logic [7:0] ADDR_VIEW = 8'h10;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

    // reset values
    localparam logic [15:0] SPD_WIN_RST = 16'h000a;
    localparam logic [15:0] POS_WIN_RST = 16'h000a;
    localparam logic [15:0] ROT_THR_RST = 16'h0014;
    localparam logic [3:0] IRQ_MASK_RST = 4'h0;

    // torque above rated by 10 percent: torque * 10 > rated * 11
    localparam logic [3:0] TRQ_NUM = 4'hb;
    localparam logic [3:0] TRQ_DEN = 4'ha;

    // field positions
    localparam int CTRL_MODE_LSB = 0;
    localparam int VIEW_TEXT_LSB = 9;
    localparam int VIEW_NUM_LSB = 12;
    localparam int IRQ_ALM_A = 0;
    localparam int IRQ_ALM_B = 1;
    localparam int IRQ_PWR_LOST = 2;
    localparam int IRQ_OVERTRAVEL = 3;

    typedef enum logic [1:0] {
        MODE_SPEED,
        MODE_TORQUE,
        MODE_POSITION
    } ctrl_mode_t;

    typedef enum logic [2:0] {
        TXT_BOTH_OFF,
        TXT_A_ON,
        TXT_B_ON,
        TXT_A_OVERTRAVEL,
        TXT_B_OVERTRAVEL,
        TXT_A_ALARM,
        TXT_B_ALARM
    } text_code_t;

    typedef struct packed {
        logic servo_on;
        logic fwd_prohibit;
        logic rev_prohibit;
        logic alarm;
        logic [7:0] alarm_num;
        logic signed [15:0] speed;
        logic signed [15:0] cmd_speed;
        logic signed [15:0] pos_err;
        logic signed [15:0] torque;
        logic [15:0] rated_torque;
    } axis_in_t;

endpackage

// >>> design/sync2.sv
// Purpose: two flip-flop synchroniser for levels from outside the clock
// Assumes: async active-low reset, resets to zero
// Notes: first stage is read by the second stage only
module sync2 #(
    parameter int W = 1
) (
    // clock and reset
    input logic i_ref_clk,
    input logic i_arst_n,
    // data
    input logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta;

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta <= '0;
            o_q <= '0;
        end else begin
            meta <= i_d;
            o_q <= meta;
        end
    end

endmodule

// >>> design/axis_compare.sv
// Purpose: window comparison and torque overload check for one axis
// Assumes: signed 16-bit operands, unsigned window
// Notes: purely combinational
module axis_compare (
    // window check
    input logic signed [15:0] i_meas,
    input logic signed [15:0] i_ref,
    input logic [15:0] i_window,
    // torque check
    input logic signed [15:0] i_torque,
    input logic [15:0] i_rated,
    // results
    output logic o_within,
    output logic o_over_torque
);

    logic signed [16:0] diff;
    logic [16:0] mag;
    logic [15:0] trq_mag;
    logic [19:0] trq_scaled;
    logic [19:0] rated_scaled;

    always_comb begin
        diff = 17'(i_meas) - 17'(i_ref);
        mag = diff[16] ? 17'(-diff) : 17'(diff);
        o_within = mag < {1'b0, i_window};
        trq_mag = i_torque[15] ? 16'(-i_torque) : 16'(i_torque);
        trq_scaled = 20'(trq_mag) * 20'(status_ind_pkg::TRQ_DEN);
        rated_scaled = 20'(i_rated) * 20'(status_ind_pkg::TRQ_NUM);
        o_over_torque = trq_scaled > rated_scaled;
    end

endmodule

// >>> tb/test_dual_axis_status_indicator.sv
// Purpose: self-checking bench for the two-axis status indicator
// Assumes: flash half period shortened to 8 cycles, rated torque 100
// Notes: inputs change by non-blocking assignment right after a rising edge
module test_dual_axis_status_indicator;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int BLINK = 8;

    logic i_ref_clk;
    logic i_arst_n;
    logic [7:0] i_addr;
    logic [31:0] i_wdata;
    logic i_wr;
    logic i_rd;
    logic [31:0] o_rdata;
    status_ind_pkg::axis_in_t i_axis_a;
    status_ind_pkg::axis_in_t i_axis_b;
    logic i_main_power_ready;
    logic i_status_mode;
    logic i_set_key;
    logic i_alarm_clear_input_n;
    logic [8:0] o_ind;
    status_ind_pkg::text_code_t o_text;
    logic [7:0] o_alarm_num;
    logic o_irq;
    int num_errors = 0;
    int checks = 0;

    status_indicator #(
        .BLINK_CYCLES(BLINK)
    ) i_dut (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .i_addr(i_addr),
        .i_wdata(i_wdata),
        .i_wr(i_wr),
        .i_rd(i_rd),
        .o_rdata(o_rdata),
        .i_axis_a(i_axis_a),
        .i_axis_b(i_axis_b),
        .i_main_power_ready(i_main_power_ready),
        .i_status_mode(i_status_mode),
        .i_set_key(i_set_key),
        .i_alarm_clear_input_n(i_alarm_clear_input_n),
        .o_ind(o_ind),
        .o_text(o_text),
        .o_alarm_num(o_alarm_num),
        .o_irq(o_irq)
    );

    initial begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end

    task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic ind(input int k, input logic e);
        check($sformatf("ind%0d", k + 1), 32'(o_ind[k]), 32'(e));
    endtask

    task automatic txt(input status_ind_pkg::text_code_t e);
        check("text", 32'(o_text), 32'(e));
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge i_ref_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge i_ref_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        d = o_rdata;
    endtask

    task automatic sv(input logic signed [15:0] s, c, p);
        @(posedge i_ref_clk);
        i_axis_a.speed <= s;
        i_axis_a.cmd_speed <= c;
        i_axis_a.pos_err <= p;
        tick(1);
    endtask

    task automatic lim(input logic [3:0] v);
        @(posedge i_ref_clk);
        {i_axis_a.fwd_prohibit, i_axis_a.rev_prohibit} <= v[3:2];
        {i_axis_b.fwd_prohibit, i_axis_b.rev_prohibit} <= v[1:0];
        tick(2);
    endtask

    // hold a panel pin active for four cycles, then leave time for the sync and edge detect
    task automatic pin(input logic clr, input logic mode);
        @(posedge i_ref_clk);
        i_status_mode <= mode;
        if (clr) i_alarm_clear_input_n <= 1'b0;
        else i_set_key <= 1'b1;
        tick(3);
        @(posedge i_ref_clk);
        i_alarm_clear_input_n <= 1'b1;
        i_set_key <= 1'b0;
        tick(6);
    endtask

    task automatic t_regs;
        logic [7:0] a[6] = '{8'h04, 8'h08, 8'h0c, 8'h18, 8'h00, 8'h1c};
        logic [31:0] e[6] = '{32'h0a, 32'h0a, 32'h14, 32'h00, 32'h00, 32'h00};
        logic [31:0] d;
        wr(8'h1c, 32'hffffffff);
        foreach (a[i]) begin
            rd(a[i], d);
            check("reg", d, e[i]);
        end
        wr(status_ind_pkg::ADDR_SPD_WIN, 32'h05);
        rd(status_ind_pkg::ADDR_SPD_WIN, d);
        check("spd_win", d, 32'h05);
        tick(1);
        check("rdata_idle", o_rdata, 32'h0);
    endtask

    task automatic t_servo;
        status_ind_pkg::text_code_t e[4] = '{status_ind_pkg::TXT_BOTH_OFF,
            status_ind_pkg::TXT_A_ON, status_ind_pkg::TXT_B_ON, status_ind_pkg::TXT_A_ON};
        for (int k = 0; k < 4; k++) begin
            @(posedge i_ref_clk);
            i_axis_a.servo_on <= k[0];
            i_axis_b.servo_on <= k[1];
            tick(1);
            ind(0, k[0]);
            ind(4, k[1]);
            txt(e[k]);
        end
    endtask

    task automatic t_window;
        sv(16'sh0064, 16'sh0060, 16'sh0000);
        ind(1, 1'b1);
        sv(16'sh0064, 16'sh005f, 16'sh0000);
        ind(1, 1'b0);
        wr(status_ind_pkg::ADDR_SPD_WIN, 32'h0a);
        for (int m = 0; m < 2; m++) begin
            wr(status_ind_pkg::ADDR_CTRL, 32'(m));
            sv(16'sh0064, 16'sh005b, 16'sh0000);
            ind(1, 1'b1);
            sv(16'sh0064, 16'sh006e, 16'sh0000);
            ind(1, 1'b0);
        end
        wr(status_ind_pkg::ADDR_CTRL, 32'h02);
        sv(16'sh0064, 16'sh0000, -16'sh0009);
        ind(1, 1'b1);
        sv(16'sh0000, 16'sh0000, 16'sh000a);
        ind(1, 1'b0);
        wr(status_ind_pkg::ADDR_CTRL, 32'h00);
    endtask

    task automatic t_analog;
        logic signed [15:0] ta[3] = '{16'sh006f, 16'sh006e, -16'sh006f};
        logic signed [15:0] tb[3] = '{16'sh006e, 16'sh006f, 16'sh0000};
        foreach (ta[i]) begin
            @(posedge i_ref_clk);
            i_axis_a.torque <= ta[i];
            i_axis_b.torque <= tb[i];
            tick(1);
            ind(2, i != 1);
            ind(5, i == 1);
        end
        @(posedge i_ref_clk);
        i_axis_b.speed <= 16'sh0032;
        i_axis_b.cmd_speed <= 16'sh001f;
        tick(1);
        ind(6, 1'b1);
        @(posedge i_ref_clk);
        i_axis_b.cmd_speed <= 16'sh001e;
        i_main_power_ready <= 1'b1;
        tick(1);
        ind(6, 1'b0);
        ind(8, 1'b1);
        @(posedge i_ref_clk);
        i_main_power_ready <= 1'b0;
        tick(1);
        ind(8, 1'b0);
    endtask

    task automatic t_limit;
        int n3 = 0;
        int n7 = 0;
        logic p3;
        logic p7;
        lim(4'b1000);
        ind(3, 1'b1);
        txt(status_ind_pkg::TXT_A_OVERTRAVEL);
        lim(4'b0100);
        ind(3, 1'b0);
        txt(status_ind_pkg::TXT_A_OVERTRAVEL);
        lim(4'b0010);
        ind(7, 1'b1);
        txt(status_ind_pkg::TXT_B_OVERTRAVEL);
        lim(4'b0001);
        ind(7, 1'b0);
        txt(status_ind_pkg::TXT_B_OVERTRAVEL);
        lim(4'b1111);
        p3 = o_ind[3];
        p7 = o_ind[7];
        repeat (4 * BLINK) begin
            tick(1);
            if (o_ind[3] !== p3) n3++;
            if (o_ind[7] !== p7) n7++;
            p3 = o_ind[3];
            p7 = o_ind[7];
        end
        check("flash4", 32'(n3 >= 3 && n3 <= 5), 32'h1);
        check("flash8", 32'(n7 >= 3 && n7 <= 5), 32'h1);
        lim(4'b0000);
        txt(status_ind_pkg::TXT_A_ON);
    endtask

    task automatic t_alarm;
        logic [31:0] d;
        @(posedge i_ref_clk);
        i_axis_a.alarm <= 1'b1;
        i_axis_a.alarm_num <= 8'h2a;
        tick(2);
        txt(status_ind_pkg::TXT_A_ALARM);
        check("alarm_num", 32'(o_alarm_num), 32'h2a);
        rd(status_ind_pkg::ADDR_VIEW, d);
        check("view", 32'(d[19:9]), 32'h155);
        pin(1'b1, 1'b0);
        txt(status_ind_pkg::TXT_A_ALARM);
        @(posedge i_ref_clk);
        i_axis_a.alarm <= 1'b0;
        tick(3);
        txt(status_ind_pkg::TXT_A_ALARM);
        pin(1'b1, 1'b0);
        txt(status_ind_pkg::TXT_A_ON);
        check("alarm_num", 32'(o_alarm_num), 32'h00);
        @(posedge i_ref_clk);
        i_axis_b.alarm <= 1'b1;
        i_axis_b.alarm_num <= 8'h33;
        tick(1);
        @(posedge i_ref_clk);
        i_axis_b.alarm <= 1'b0;
        tick(2);
        txt(status_ind_pkg::TXT_B_ALARM);
        check("alarm_num", 32'(o_alarm_num), 32'h33);
        pin(1'b0, 1'b0);
        txt(status_ind_pkg::TXT_B_ALARM);
        pin(1'b0, 1'b1);
        txt(status_ind_pkg::TXT_A_ON);
    endtask

    task automatic t_irq;
        logic [31:0] d;
        wr(status_ind_pkg::ADDR_IRQ_STAT, 32'h0f);
        rd(status_ind_pkg::ADDR_IRQ_STAT, d);
        check("irq_stat", d, 32'h00);
        check("irq", 32'(o_irq), 32'h0);
        lim(4'b1000);
        lim(4'b0000);
        rd(status_ind_pkg::ADDR_IRQ_STAT, d);
        check("irq_stat", d, 32'h08);
        wr(status_ind_pkg::ADDR_IRQ_MASK, 32'h01);
        tick(1);
        check("irq", 32'(o_irq), 32'h0);
        wr(status_ind_pkg::ADDR_IRQ_MASK, 32'h08);
        tick(1);
        check("irq", 32'(o_irq), 32'h1);
        wr(status_ind_pkg::ADDR_IRQ_STAT, 32'h08);
        tick(1);
        check("irq", 32'(o_irq), 32'h0);
        rd(status_ind_pkg::ADDR_IRQ_MASK, d);
        check("irq_mask", d, 32'h08);
    endtask

    task automatic test_done;
        if (num_errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        #100000;
        num_errors++;
        test_done();
    end

    initial begin
        i_arst_n = 1'b0;
        i_addr = 8'h00;
        i_wdata = 32'h0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_axis_a = '0;
        i_axis_b = '0;
        i_axis_a.rated_torque = 16'h0064;
        i_axis_b.rated_torque = 16'h0064;
        i_main_power_ready = 1'b0;
        i_status_mode = 1'b0;
        i_set_key = 1'b0;
        i_alarm_clear_input_n = 1'b1;
        tick(2);
        check("ind_rst", 32'(o_ind), 32'h0);
        check("irq_rst", 32'(o_irq), 32'h0);
        @(posedge i_ref_clk);
        i_arst_n <= 1'b1;
        tick(3);
        t_regs();
        t_window();
        t_analog();
        t_servo();
        t_limit();
        t_alarm();
        t_irq();
        test_done();
    end
endmodule
